// *** rtl/vsc_pkg.sv ***
// vsc_pkg: constants and types for the serial command front end
// assumes a 40 MHz system clock; serial pins are asynchronous
package vsc_pkg;
  localparam logic [1:0] CMD_MODE = 2'h0;
  localparam logic [1:0] CMD_DATA = 2'h1;
  localparam logic [1:0] CMD_DCTL = 2'h2;
  localparam logic [1:0] CMD_ADDR = 2'h3;
  localparam logic [1:0] DS_DRAM_WR = 2'h0;
  localparam logic [1:0] DS_LED_WR = 2'h1;
  localparam logic [1:0] DS_KEY_RD = 2'h2;
  localparam logic [1:0] DS_SW_RD = 2'h3;
  localparam int DS_FIXED_BIT = 2;
  localparam int DCTL_ON_BIT = 3;
  localparam logic [3:0] MODE_RESET = 4'hF;
  localparam logic [3:0] DSET_RESET = 4'h0;
  localparam logic [4:0] LED_RESET = 5'h1F;
  localparam logic [2:0] PW_RESET = 3'h0;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam logic [5:0] ADDR_LAST = 6'h2F;
  localparam int RAM_BYTES = 48;
  localparam int KEY_BYTES = 6;
  localparam int KEY_SRC = 12;
  localparam int SCAN_CYCLES = 2000;
  localparam int TWAIT_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int TWAIT_CYC = (TWAIT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b10
  } vsc_state_t;

  typedef struct packed {
    logic [2:0] pulse_width;
    logic display_on;
  } vsc_dctl_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] dset;
  } vsc_cfg_t;
endpackage

// *** rtl/vsc_sync.sv ***
// vsc_sync: two-flop synchroniser for a bus of asynchronous levels
// assumes clock_in is the only clock
`timescale 1ns/1ps
module vsc_sync #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // vsc_sync

// *** rtl/vsc_top.sv ***
// vsc_top: serial command interpreter with display ram, key store, indicator_output_port
// assumes the host pins are asynchronous to clock_in and sampled here
`timescale 1ns/1ps
module vsc_top
  import vsc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // host serial pins
  input wire logic frame_select_in,
  input wire logic shift_clk_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n_out,
  // key and general inputs
  input wire logic [3:0] key_return_inputs_in,
  input wire logic [3:0] general_inputs_in,
  // key source index being scanned
  output logic [3:0] segment_key_source_out,
  // indicators and state
  output logic [4:0] led_n_out,
  output logic [3:0] display_mode_out,
  output logic display_on_out,
  output logic [2:0] pulse_width_out,
  output logic key_scan_out
);
  logic [2:0] pins_s;
  logic [3:0] keys_s;
  logic [3:0] sw_s;
  logic stb_s, sck_s, din_s, sck_d_reg;
  logic sck_rise, sck_fall;
  vsc_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done;
  logic [7:0] rx_byte;
  vsc_cfg_t cfg_reg;
  vsc_dctl_t dctl_reg;
  logic [5:0] addr_reg;
  logic [7:0] ram_mem [RAM_BYTES];
  logic [3:0] key_mem [KEY_SRC];
  logic [4:0] led_reg;
  logic [7:0] tx_reg;
  logic [2:0] tx_cnt_reg;
  logic [2:0] key_idx_reg;
  logic reading;
  logic [10:0] scan_cnt_reg;
  logic [3:0] src_reg;
  logic scan_end;

  vsc_sync #(.W(3)) u_pin_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({frame_select_in, shift_clk_in, data_in}),
    .sync_out(pins_s)
  );
  vsc_sync #(.W(8)) u_in_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({key_return_inputs_in, general_inputs_in}),
    .sync_out({keys_s, sw_s})
  );
  assign stb_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign din_s = pins_s[0];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) sck_d_reg <= 1'b1;
    else sck_d_reg <= sck_s;
  end
  // edges only count while strobe low
  assign sck_rise = ~stb_s & sck_s & ~sck_d_reg;
  assign sck_fall = ~stb_s & ~sck_s & sck_d_reg;
  assign rx_byte = {din_s, shift_reg[7:1]};
  assign byte_done = sck_rise && bit_cnt_reg == 3'h7;
  assign reading = cfg_reg.dset[1];

  // frame state: first byte after strobe fall is the command
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
    end else if (stb_s) begin
      state_reg <= ST_IDLE;
    end else if (state_reg == ST_IDLE) begin
      state_reg <= ST_CMD;
    end else if (byte_done && state_reg == ST_CMD) begin
      state_reg <= ST_DATA;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || stb_s) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // command decode and configuration
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_reg.mode <= MODE_RESET;
      cfg_reg.dset <= DSET_RESET;
      dctl_reg.display_on <= 1'b0;
      dctl_reg.pulse_width <= PW_RESET;
      addr_reg <= ADDR_RESET;
    end else if (byte_done && state_reg == ST_CMD) begin
      case (rx_byte[7:6])
        CMD_MODE: begin
          if (rx_byte[3:0] != cfg_reg.mode) begin
            cfg_reg.mode <= rx_byte[3:0];
            dctl_reg.display_on <= 1'b0;
          end
        end
        CMD_DATA: cfg_reg.dset <= rx_byte[3:0];
        CMD_DCTL: begin
          dctl_reg.display_on <= rx_byte[DCTL_ON_BIT];
          dctl_reg.pulse_width <= rx_byte[2:0];
        end
        CMD_ADDR: addr_reg <= rx_byte[5:0];
        default: ;
      endcase
    end else if (byte_done && state_reg == ST_DATA && !reading
                 && cfg_reg.dset[1:0] == DS_DRAM_WR && addr_reg <= ADDR_LAST) begin
      if (!cfg_reg.dset[DS_FIXED_BIT]) addr_reg <= addr_reg + 6'h01;
    end
  end

  // display ram, three bytes per digit
  always_ff @(posedge clock_in) begin
    if (byte_done && state_reg == ST_DATA && cfg_reg.dset[1:0] == DS_DRAM_WR
        && addr_reg <= ADDR_LAST) begin
      ram_mem[addr_reg] <= rx_byte;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      led_reg <= LED_RESET;
    end else if (byte_done && state_reg == ST_DATA && cfg_reg.dset[1:0] == DS_LED_WR) begin
      led_reg <= rx_byte[4:0];
    end
  end

  // key scan timing: one display cycle walks all key sources
  assign scan_end = dctl_reg.display_on && scan_cnt_reg == 11'(SCAN_CYCLES - 1);
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !dctl_reg.display_on) begin
      scan_cnt_reg <= 11'h000;
      src_reg <= 4'h0;
    end else if (scan_end) begin
      scan_cnt_reg <= 11'h000;
      src_reg <= (src_reg == 4'(KEY_SRC - 1)) ? 4'h0 : src_reg + 4'h1;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 11'h001;
    end
  end

  // scan stops with the display, so latching stops too
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < KEY_SRC; i++) key_mem[i] <= 4'h0;
    end else if (scan_end) begin
      key_mem[src_reg] <= keys_s;
    end
  end

  // read-back: load on command end or, in key read, on byte exhaustion; shift on falls
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || stb_s) begin
      tx_reg <= 8'hFF;
      tx_cnt_reg <= 3'h0;
      key_idx_reg <= 3'h0;
      data_out <= 1'b1;
      data_oe_n_out <= 1'b1;
    end else if (byte_done && state_reg == ST_CMD && rx_byte[7:6] == CMD_DATA
                 && rx_byte[1]) begin
      tx_reg <= (rx_byte[1:0] == DS_SW_RD) ? {4'h0, sw_s}
                : {key_mem[1], key_mem[0]};
      tx_cnt_reg <= 3'h0;
      key_idx_reg <= 3'h1;
    end else if (sck_fall && state_reg == ST_DATA && reading) begin
      data_out <= tx_reg[tx_cnt_reg];
      data_oe_n_out <= tx_reg[tx_cnt_reg];
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h7 && cfg_reg.dset[1:0] == DS_KEY_RD) begin
        tx_reg <= {key_mem[{key_idx_reg, 1'b1}], key_mem[{key_idx_reg, 1'b0}]};
        key_idx_reg <= (key_idx_reg == 3'(KEY_BYTES - 1)) ? 3'h0 : key_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      led_n_out <= LED_RESET;
      display_mode_out <= MODE_RESET;
      display_on_out <= 1'b0;
      pulse_width_out <= PW_RESET;
      key_scan_out <= 1'b0;
      segment_key_source_out <= 4'h0;
    end else begin
      led_n_out <= led_reg;
      display_mode_out <= cfg_reg.mode;
      display_on_out <= dctl_reg.display_on;
      pulse_width_out <= dctl_reg.pulse_width;
      key_scan_out <= dctl_reg.display_on;
      segment_key_source_out <= src_reg;
    end
  end

  AST_LED_RESET: assert property (@(posedge clock_in)
    $fell(sys_rst_in) |-> led_n_out == LED_RESET)
    else $error("indicator_output_port not off after reset");
  AST_MODE_OFF: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_CMD && rx_byte[7:6] == CMD_MODE
     && rx_byte[3:0] != cfg_reg.mode) |=> ##1 !display_on_out)
    else $error("mode change left display on");
  AST_SAME_MODE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_CMD && rx_byte[7:6] == CMD_MODE
     && rx_byte[3:0] == cfg_reg.mode) |=> $stable(dctl_reg))
    else $error("same mode changed display");
  AST_STB_IDLE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    stb_s |=> bit_cnt_reg == 3'h0 && data_oe_n_out)
    else $error("activity while strobe high");
  AST_INC: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_DATA && cfg_reg.dset == 4'h0 && addr_reg < ADDR_LAST)
    |=> addr_reg == $past(addr_reg) + 6'h01)
    else $error("address did not advance");
  AST_ADDR_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_DATA && addr_reg > ADDR_LAST) |=> $stable(addr_reg))
    else $error("invalid address moved");
  AST_LED_WR: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_DATA && cfg_reg.dset[1:0] == DS_LED_WR)
    |=> ##1 led_n_out == $past(rx_byte[4:0], 2))
    else $error("led write mismatch");
  AST_DSET: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (byte_done && state_reg == ST_CMD && rx_byte[7:6] == CMD_DATA)
    |=> cfg_reg.dset == $past(rx_byte[3:0]))
    else $error("data setting not stored");

  // the two byte kinds that most checks start from
  sequence cmd_byte_s;
    byte_done && state_reg == ST_CMD;
  endsequence
  sequence data_byte_s;
    byte_done && state_reg == ST_DATA;
  endsequence
  AST_MODE_SET: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cmd_byte_s ##0 (rx_byte[7:6] == CMD_MODE) |=> cfg_reg.mode == $past(rx_byte[3:0]))
    else $error("mode code not stored");
  AST_DCTL_ON: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cmd_byte_s ##0 (rx_byte[7:6] == CMD_DCTL)
    |=> ##1 display_on_out == $past(rx_byte[DCTL_ON_BIT], 2))
    else $error("display control not applied");
  AST_ADDR_SET: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cmd_byte_s ##0 (rx_byte[7:6] == CMD_ADDR) |=> addr_reg == $past(rx_byte[5:0]))
    else $error("address not stored");
  AST_PARTIAL: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (stb_s && bit_cnt_reg != 3'h0) |=> bit_cnt_reg == 3'h0 && $stable(led_reg))
    else $error("partial byte kept");
  AST_RAM_WR: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    data_byte_s ##0 (cfg_reg.dset[1:0] == DS_DRAM_WR && addr_reg <= ADDR_LAST)
    |=> ram_mem[$past(addr_reg)] == $past(rx_byte))
    else $error("ram byte not stored");
  AST_KEY_LATCH: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    scan_end |=> key_mem[$past(src_reg)] == $past(keys_s))
    else $error("key returns not latched");
  AST_OPEN_DRAIN: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !data_oe_n_out |-> !data_out)
    else $error("data out driven high");
  AST_SCAN_STOP: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !dctl_reg.display_on |=> scan_cnt_reg == 11'h000 && src_reg == 4'h0)
    else $error("key scan ran with display off");
endmodule // vsc_top

// *** verif/vsc_host.sv ***
// vsc_host: host side of the strobe / shift clock / data serial link
// assumes the bench supplies clock_in; all pin changes follow its rising edge
`timescale 1ns/1ps
module vsc_host (
  // clock
  input wire logic clock_in,
  // serial pins
  output logic frame_select_out,
  output logic shift_clk_out,
  output logic host_data_out,
  input wire logic resp_in
);
  initial begin
    frame_select_out = 1'b1;
    shift_clk_out = 1'b1;
    host_data_out = 1'b0;
  end
  task automatic open_frame();
    @(posedge clock_in);
    frame_select_out <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic close_frame();
    repeat (4) @(posedge clock_in);
    frame_select_out <= 1'b1;
    // released line must not keep its last level
    host_data_out <= ~host_data_out;
    repeat (8) @(posedge clock_in);
  endtask
  // n bits each way, lsb first, 200 ns shift period
  task automatic shift(input logic [7:0] v, input int n, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      shift_clk_out <= 1'b0;
      host_data_out <= v[i];
      repeat (4) @(posedge clock_in);
      shift_clk_out <= 1'b1;
      repeat (3) @(posedge clock_in);
      got[i] = resp_in;
    end
  endtask
  task automatic wait_read();
    repeat (44) @(posedge clock_in);
  endtask
endmodule // vsc_host

// *** verif/vsc_top_test.sv ***
// vsc_top_test: self-checking bench for the serial command front end
// assumes vsc_top and vsc_host; data out pin has a pull-up
`timescale 1ns/1ps
module vsc_top_test;
  import vsc_pkg::*;
  logic clock_in, sys_rst_in, frame_sel, sclk, hdata, dout, dout_oe_n, scan_on, disp_on;
  logic [3:0] keys, sw, src, mode;
  logic [4:0] led_n;
  logic [2:0] pw;
  logic [7:0] got;
  int errors, cmp_count;
  wire dout_pin = dout_oe_n | dout;

  vsc_top vsc_top_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .frame_select_in(frame_sel), .shift_clk_in(sclk), .data_in(hdata), .data_out(dout),
    .data_oe_n_out(dout_oe_n), .key_return_inputs_in(keys), .general_inputs_in(sw),
    .segment_key_source_out(src), .led_n_out(led_n), .display_mode_out(mode),
    .display_on_out(disp_on), .pulse_width_out(pw), .key_scan_out(scan_on));
  vsc_host vsc_host_inst (.clock_in(clock_in), .frame_select_out(frame_sel),
    .shift_clk_out(sclk), .host_data_out(hdata), .resp_in(dout_pin));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // each source returns its own index, so nibble and byte order both show
  always @(posedge clock_in) keys <= src;

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] d, input int n);
    vsc_host_inst.open_frame();
    vsc_host_inst.shift(cmd, 8, got);
    if (n > 0) vsc_host_inst.shift(d, n, got);
    vsc_host_inst.close_frame();
  endtask
  task automatic state_byte(output logic [7:0] s);
    s = {disp_on, scan_on, 3'h0, pw};
  endtask

  task automatic test_reset();
    logic [7:0] s;
    state_byte(s);
    cmp8({3'h0, led_n}, 8'h1F);
    cmp8({4'h0, mode}, {4'h0, MODE_RESET});
    cmp8(s, 8'h00);
    cmp8({6'h0, dout, dout_oe_n}, 8'h03);
    cmp8({4'h0, src}, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_led();
    frame(8'h71, 8'hE5, 8);
    cmp8({3'h0, led_n}, 8'h05);
    frame(8'h41, 8'h00, 5);
    cmp8({3'h0, led_n}, 8'h05);
    vsc_host_inst.shift(8'h00, 8, got);
    cmp8({2'h0, dout_oe_n, led_n}, 8'h25);
    $display("test_led done");
  endtask
  task automatic test_mode();
    logic [7:0] s;
    for (int i = 0; i < 8; i++) begin
      frame(8'h38 + 8'(i), 8'h00, 0);
      cmp8({4'h0, mode}, 8'h08 + 8'(i));
    end
    frame(8'h8B, 8'h00, 0);
    frame(8'h0F, 8'h00, 0);
    state_byte(s);
    cmp8(s, 8'hC3);
    frame(8'h0A, 8'h00, 0);
    state_byte(s);
    cmp8(s, 8'h03);
    $display("test_mode done");
  endtask
  task automatic test_switch();
    sw <= 4'hA;
    vsc_host_inst.open_frame();
    vsc_host_inst.shift(8'h43, 8, got);
    vsc_host_inst.wait_read();
    vsc_host_inst.shift(8'hFF, 8, got);
    vsc_host_inst.close_frame();
    cmp8(got, 8'h0A);
    $display("test_switch done");
  endtask
  task automatic test_ram();
    frame(8'h40, 8'h00, 0);
    vsc_host_inst.open_frame();
    vsc_host_inst.shift(8'hEE, 8, got);
    vsc_host_inst.shift(8'h11, 8, got);
    vsc_host_inst.shift(8'h22, 8, got);
    vsc_host_inst.shift(8'h33, 8, got);
    vsc_host_inst.close_frame();
    cmp8(vsc_top_inst.ram_mem[46], 8'h11);
    cmp8(vsc_top_inst.ram_mem[47], 8'h22);
    cmp8({2'h0, vsc_top_inst.addr_reg}, 8'h30);
    frame(8'h44, 8'h00, 0);
    vsc_host_inst.open_frame();
    vsc_host_inst.shift(8'hC5, 8, got);
    vsc_host_inst.shift(8'hAA, 8, got);
    vsc_host_inst.shift(8'hBB, 8, got);
    vsc_host_inst.close_frame();
    cmp8(vsc_top_inst.ram_mem[5], 8'hBB);
    cmp8({2'h0, vsc_top_inst.addr_reg}, 8'h05);
    $display("test_ram done");
  endtask
  task automatic test_keys();
    frame(8'h8F, 8'h00, 0);
    repeat (25000) @(posedge clock_in);
    vsc_host_inst.open_frame();
    vsc_host_inst.shift(8'h42, 8, got);
    vsc_host_inst.wait_read();
    for (int b = 0; b < KEY_BYTES; b++) begin
      vsc_host_inst.shift(8'hFF, 8, got);
      cmp8(got, {4'(2 * b + 1), 4'(2 * b)});
    end
    vsc_host_inst.close_frame();
    $display("test_keys done");
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst_in = 1'b1;
    sw = 4'h0;
    repeat (16) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    test_reset();
    test_led();
    test_mode();
    test_switch();
    test_ram();
    test_keys();
    give_verdict();
  end
  // keys test alone needs about 25600 cycles
  initial begin
    repeat (80000) @(posedge clock_in);
    errors++;
    give_verdict();
  end
endmodule // vsc_top_test
